/* logic/acc_consts.svh */
// register map, field positions, reset values and timing counts of the conversion control
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// byte addresses of the register words
`define ACC_ADDR_CTRL     32'hFFFF0500
`define ACC_ADDR_POS      32'hFFFF0504
`define ACC_ADDR_NEG      32'hFFFF0508
`define ACC_ADDR_STAT     32'hFFFF050C
`define ACC_ADDR_DATA     32'hFFFF0510
`define ACC_ADDR_RST      32'hFFFF0514

// reset values
`define ACC_RST_CTRL      16'h0600
`define ACC_RST_POS       5'h00
`define ACC_RST_NEG       5'h01
`define ACC_CTRL_WMASK    16'h3FFF

// converter_control field positions
`define ACC_EDGE          13
`define ACC_DIV_HI        12
`define ACC_DIV_LO        10
`define ACC_ACQ_HI        9
`define ACC_ACQ_LO        8
`define ACC_EN            7
`define ACC_BUSY_EN       6
`define ACC_PWR           5
`define ACC_MODE_HI       4
`define ACC_MODE_LO       3
`define ACC_SRC_HI        2
`define ACC_SRC_LO        0

// status field positions
`define ACC_STAT_READY    0
`define ACC_STAT_PWR_OK   1

// trigger source codes
`define ACC_SRC_EXT       3'h0
`define ACC_SRC_TMR1      3'h1
`define ACC_SRC_TMR0      3'h2
`define ACC_SRC_SINGLE    3'h3
`define ACC_SRC_CONT      3'h4
`define ACC_SRC_LOGIC     3'h5

// input mode codes
`define ACC_MODE_DIFF     2'h1

// temperature channel and its forced timing codes
`define ACC_TEMP_CH       5'h10
`define ACC_TEMP_DIV      3'h5
`define ACC_TEMP_ACQ      2'h3
`define ACC_DIV_MAX       3'h5

// conversion timing in converter clocks
`define ACC_TRIALS        5'd12
`define ACC_EXTRA_LAST    5'd18

// power-up settling
`define ACC_CLK_NS        100
`define ACC_PWRUP_NS      5000
`define ACC_PWRUP_CYC     ((`ACC_PWRUP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)

`endif

/* logic/acc_pkg.sv */
// types shared by the conversion control logic
package acc_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_ACQ,
        ACC_CONV
    } acc_state_t;

    // trigger inputs from the rest of the chip
    typedef struct packed {
        logic ext_pin;
        logic tmr1_ovf;
        logic tmr0_ovf;
        logic logic_array_out;
    } acc_trig_t;

    // controls towards the converter core and multiplexer
    typedef struct packed {
        logic        power;
        logic        track;
        logic [1:0]  mode;
        logic [4:0]  pos_ch;
        logic [4:0]  neg_ch;
        logic [11:0] trial;
    } acc_core_t;

endpackage : acc_pkg

/* logic/acc_ctrl.sv */
// conversion control, trigger, timing and result formatting with apb registers
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.svh"

module acc_ctrl
    import acc_pkg::*;
(
    input  wire logic        pclk,          // bus and logic clock
    input  wire logic        presetn,       // asynchronous reset, active low
    input  wire logic        ce,            // clock enable, freezes all state
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [31:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error on unmapped address
    input  wire acc_trig_t   trig,          // trigger sources
    input  wire logic        core_cmp,      // comparator: trial code not above input
    output acc_core_t        core_ctl,      // converter core controls
    output logic             conversion_busy_pin,    // busy indication
    output logic             conversion_busy_pin_oe  // busy pin drive enable
);

    // register state
    logic [15:0] converter_control;     // control word
    logic [4:0]  positive_input_select; // positive channel
    logic [4:0]  negative_input_select; // negative channel
    logic        result_ready_flag;     // result waiting
    logic [31:0] conversion_result;     // formatted result

    // sequencer state
    acc_state_t  state;                 // current phase
    logic [4:0]  div_cnt;               // converter clock prescaler
    logic [4:0]  phase_cnt;             // converter clocks in phase
    logic [11:0] sar;                   // trial code
    logic [4:0]  div_lim;               // latched divider limit
    logic [4:0]  acq_lim;               // latched acquisition limit
    logic        temp_conv;             // running a temperature conversion
    logic        temp_hold;             // temperature result not yet read
    logic        cont_run;              // continuous sequence active
    logic        trig_prev;             // previous trigger level
    logic        busy_q;                // registered busy pin
    logic [5:0]  pwr_cnt;               // power-up settling count
    logic        pwr_ok;                // settling done

    // decoded bus access
    logic        setup;                 // setup phase
    logic        access;                // access phase, completes this edge
    logic        wr;                    // write completes
    logic        rd;                    // read completes
    logic        hit_ctrl;              // address decodes
    logic        hit_pos;
    logic        hit_neg;
    logic        hit_stat;
    logic        hit_data;
    logic        hit_rst;
    logic        mapped;                // any register decoded
    logic        soft_rst;              // register-file reset pulse

    // control fields
    logic [2:0]  src;                   // trigger source
    logic        powered;               // normal mode
    logic        trig_sel;              // selected hardware trigger level
    logic        trig_hit;              // hardware trigger seen
    logic        start;                 // start conversion now
    logic        tick;                  // one converter clock elapsed
    logic        done;                  // conversion writes its result
    logic        temp_force;            // temperature timing in force
    logic [2:0]  div_code;              // divider code in use
    logic [1:0]  acq_code;              // acquisition code in use
    logic [4:0]  next_div_lim;          // divider limit for next start
    logic [4:0]  next_acq_lim;          // acquisition limit for next start
    logic [31:0] next_prdata;           // read mux
    logic [31:0] next_result;           // result word written at done

    // apb decode
    assign setup    = psel & ~penable;
    assign access   = psel & penable & ce;
    assign wr       = access & pwrite;
    assign rd       = access & ~pwrite;
    assign hit_ctrl = (paddr == `ACC_ADDR_CTRL);
    assign hit_pos  = (paddr == `ACC_ADDR_POS);
    assign hit_neg  = (paddr == `ACC_ADDR_NEG);
    assign hit_stat = (paddr == `ACC_ADDR_STAT);
    assign hit_data = (paddr == `ACC_ADDR_DATA);
    assign hit_rst  = (paddr == `ACC_ADDR_RST);
    assign mapped   = hit_ctrl | hit_pos | hit_neg | hit_stat | hit_data | hit_rst;
    assign soft_rst = wr & hit_rst;

    // zero wait states; frozen while the enable is low
    assign pready  = ce;
    assign pslverr = psel & penable & ~mapped;

    // field extraction
    assign src     = converter_control[`ACC_SRC_HI:`ACC_SRC_LO];
    assign powered = converter_control[`ACC_PWR];

    // source selection of hardware triggers
    always_comb
    begin
        unique case (src)
            `ACC_SRC_TMR1: trig_sel = trig.tmr1_ovf;
            `ACC_SRC_TMR0: trig_sel = trig.tmr0_ovf;
            `ACC_SRC_LOGIC: trig_sel = trig.logic_array_out;
            `ACC_SRC_EXT:  trig_sel = trig.ext_pin;
            default:       trig_sel = 1'b0;
        endcase
    end

    // edge or level detection
    assign trig_hit = converter_control[`ACC_EDGE] ? (trig_sel & ~trig_prev) : trig_sel;

    // start decision, software or hardware
    always_comb
    begin
        start = 1'b0;
        if (state == ACC_IDLE && powered && !soft_rst)
        begin
            unique case (src)
                // single shot, cleared afterwards
                `ACC_SRC_SINGLE: start = converter_control[`ACC_EN];
                // continuous keeps running once begun
                `ACC_SRC_CONT:   start = converter_control[`ACC_EN] | cont_run;
                // reserved codes never start
                3'h6, 3'h7:      start = 1'b0;
                default:         start = converter_control[`ACC_EN] & trig_hit;
            endcase
        end
    end

    // temperature channel timing override
    assign temp_force = (positive_input_select == `ACC_TEMP_CH) | temp_hold;
    assign div_code   = temp_force ? `ACC_TEMP_DIV
                                   : converter_control[`ACC_DIV_HI:`ACC_DIV_LO];
    assign acq_code   = temp_force ? `ACC_TEMP_ACQ
                                   : converter_control[`ACC_ACQ_HI:`ACC_ACQ_LO];

    // divisor 1 << code, reserved codes clamp to 32
    always_comb
    begin
        if (div_code > `ACC_DIV_MAX)
            next_div_lim = 5'h1F;
        else
            next_div_lim = 5'((6'h01 << div_code) - 6'h01);
    end

    // acquisition clocks 2 << code
    assign next_acq_lim = 5'((6'h02 << acq_code) - 6'h01);

    // converter clock tick
    assign tick = (state != ACC_IDLE) && (div_cnt == div_lim);
    assign done = tick && (state == ACC_CONV) && (phase_cnt == `ACC_EXTRA_LAST);

    // result formatting
    function automatic logic [31:0] acc_format(input logic [11:0] code,
                                               input logic        diff);
        logic [11:0] tc;
        logic [11:0] sh;
        tc = code ^ 12'h800;
        sh = {tc[11], tc[11:1]};
        if (diff)
            acc_format = {{4{sh[11]}}, sh, 16'h0000};
        else
            acc_format = {4'h0, code, 16'h0000};
    endfunction : acc_format

    // result word as written at the end of a conversion
    assign next_result = acc_format(sar,
        converter_control[`ACC_MODE_HI:`ACC_MODE_LO] == `ACC_MODE_DIFF);

    // converter_control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            converter_control <= `ACC_RST_CTRL;
        else if (ce)
        begin
            if (soft_rst)
                converter_control <= `ACC_RST_CTRL;
            else if (wr && hit_ctrl)
                converter_control <= pwdata[15:0] & `ACC_CTRL_WMASK;
            else if (done && src == `ACC_SRC_SINGLE)
                converter_control[`ACC_SRC_HI:`ACC_SRC_LO] <= `ACC_SRC_EXT;
        end
    end

    // channel select registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            positive_input_select <= `ACC_RST_POS;
            negative_input_select <= `ACC_RST_NEG;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                positive_input_select <= `ACC_RST_POS;
                negative_input_select <= `ACC_RST_NEG;
            end
            else if (wr && hit_pos)
                positive_input_select <= pwdata[4:0];
            else if (wr && hit_neg)
                negative_input_select <= pwdata[4:0];
        end
    end

    // ready flag, set wins over the read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_ready_flag <= 1'b0;
        else if (ce)
        begin
            if (done)
                result_ready_flag <= 1'b1;
            else if (soft_rst || (rd && hit_data))
                result_ready_flag <= 1'b0;
        end
    end

    // result register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conversion_result <= 32'h00000000;
        else if (ce)
        begin
            if (soft_rst)
                conversion_result <= 32'h00000000;
            else if (done)
                conversion_result <= next_result;
        end
    end

    // temperature hold until the result is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            temp_conv <= 1'b0;
            temp_hold <= 1'b0;
        end
        else if (ce)
        begin
            if (start)
                temp_conv <= (positive_input_select == `ACC_TEMP_CH);
            if (done && temp_conv)
                temp_hold <= 1'b1;
            else if (soft_rst || (rd && hit_data))
                temp_hold <= 1'b0;
        end
    end

    // continuous sequence tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cont_run <= 1'b0;
        else if (ce)
        begin
            if (soft_rst || !powered || src != `ACC_SRC_CONT)
                cont_run <= 1'b0;
            else if (start)
                cont_run <= 1'b1;
        end
    end

    // trigger history for edge mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_prev <= 1'b0;
        else if (ce)
            trig_prev <= trig_sel;
    end

    // sequencer: acquisition, trials, write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= ACC_IDLE;
            div_cnt   <= 5'h00;
            phase_cnt <= 5'h00;
            sar       <= 12'h000;
            div_lim   <= 5'h00;
            acq_lim   <= 5'h00;
        end
        else if (ce)
        begin
            if (soft_rst || !powered)
            begin
                // power-down or reset aborts
                state   <= ACC_IDLE;
                div_cnt <= 5'h00;
            end
            else if (start)
            begin
                // latch timing for this conversion
                state     <= ACC_ACQ;
                div_cnt   <= 5'h00;
                phase_cnt <= 5'h00;
                div_lim   <= next_div_lim;
                acq_lim   <= next_acq_lim;
            end
            else if (state != ACC_IDLE)
            begin
                div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
                if (tick)
                begin
                    unique case (state)
                        ACC_ACQ:
                        begin
                            if (phase_cnt == acq_lim)
                            begin
                                // sampling over, first trial
                                state     <= ACC_CONV;
                                phase_cnt <= 5'h00;
                                sar       <= 12'h800;
                            end
                            else
                                phase_cnt <= phase_cnt + 5'h01;
                        end
                        ACC_CONV:
                        begin
                            if (phase_cnt < `ACC_TRIALS)
                            begin
                                // keep or drop the bit, try the next
                                if (!core_cmp)
                                    sar[4'(11 - phase_cnt)] <= 1'b0;
                                if (phase_cnt < `ACC_TRIALS - 5'd1)
                                    sar[4'(10 - phase_cnt)] <= 1'b1;
                            end
                            if (done)
                                state <= ACC_IDLE;
                            else
                                phase_cnt <= phase_cnt + 5'h01;
                        end
                        default:
                            state <= ACC_IDLE;
                    endcase
                end
            end
        end
    end

    // power-up settling counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_cnt <= 6'h00;
            pwr_ok  <= 1'b0;
        end
        else if (ce)
        begin
            if (!powered || soft_rst)
            begin
                pwr_cnt <= 6'h00;
                pwr_ok  <= 1'b0;
            end
            else if (pwr_cnt == 6'(`ACC_PWRUP_CYC - 1))
                pwr_ok <= 1'b1;
            else
                pwr_cnt <= pwr_cnt + 6'h01;
        end
    end

    // busy pin, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_q <= 1'b0;
        else if (ce)
            busy_q <= converter_control[`ACC_BUSY_EN] &&
                      (start || (state != ACC_IDLE && !done));
    end

    assign conversion_busy_pin    = busy_q;
    assign conversion_busy_pin_oe = converter_control[`ACC_BUSY_EN];

    // read mux
    always_comb
    begin
        next_prdata = 32'h00000000;
        if (hit_ctrl)
            next_prdata = {16'h0000, converter_control};
        else if (hit_pos)
            next_prdata = {27'h0, positive_input_select};
        else if (hit_neg)
            next_prdata = {27'h0, negative_input_select};
        else if (hit_stat)
            next_prdata = {30'h0, pwr_ok, result_ready_flag};
        else if (hit_data)
            // a result written at this edge passes through, so the read clear never loses it
            next_prdata = done ? next_result : conversion_result;
    end

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (ce && setup)
            prdata <= next_prdata;
    end

    // core controls
    assign core_ctl.power  = powered;
    assign core_ctl.track  = (state == ACC_ACQ);
    assign core_ctl.mode   = converter_control[`ACC_MODE_HI:`ACC_MODE_LO];
    assign core_ctl.pos_ch = positive_input_select;
    assign core_ctl.neg_ch = negative_input_select;
    assign core_ctl.trial  = sar;

endmodule : acc_ctrl
`default_nettype wire

/* sim/acc_core_model.sv */
// comparator model of the converter core seen by the conversion control
`timescale 1ns/1ns
`default_nettype none

module acc_core_model
    import acc_pkg::*;
(
    input  wire acc_core_t   core_ctl,  // trial code and power from the block
    input  wire logic [11:0] level,     // held input level as a code
    output logic             core_cmp   // high when trial is not above level
);
    // a powered-down core gives no useful answer, so it reports low
    assign core_cmp = core_ctl.power && (core_ctl.trial <= level);
endmodule : acc_core_model
`default_nettype wire

/* sim/acc_ctrl_chk.sv */
// port assertions for the conversion control block
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.svh"

module acc_ctrl_chk
    import acc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire acc_trig_t   trig,
    input wire logic        core_cmp,
    input wire acc_core_t   core_ctl,
    input wire logic        conversion_busy_pin,
    input wire logic        conversion_busy_pin_oe
);
    logic        wr_ctrl;   // control write taken this edge
    logic [11:0] busy_cnt;  // length of the present busy pulse

    assign wr_ctrl = psel && penable && pwrite && ce && (paddr == `ACC_ADDR_CTRL);

    // count busy cycles, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_cnt <= 12'h000;
        else if (!conversion_busy_pin)
            busy_cnt <= 12'h000;
        else if (busy_cnt != 12'hFFF)
            busy_cnt <= busy_cnt + 12'h001;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_oe_from_write:
        assert property (wr_ctrl |=> conversion_busy_pin_oe == $past(pwdata[6]))
        else $error("busy enable wrong after write");
    chk_power_from_write:
        assert property (wr_ctrl |=> core_ctl.power == $past(pwdata[5]))
        else $error("power wrong after write");
    chk_mode_from_write:
        assert property (wr_ctrl |=> core_ctl.mode == $past(pwdata[4:3]))
        else $error("mode wrong after write");
    chk_busy_needs_oe:
        assert property (!conversion_busy_pin_oe [*2] |-> !conversion_busy_pin)
        else $error("busy high while disabled");
    chk_busy_unpowered:
        assert property (!core_ctl.power [*3] |-> !conversion_busy_pin)
        else $error("busy high while powered down");
    chk_track_unpowered:
        assert property (!core_ctl.power [*2] |-> !core_ctl.track)
        else $error("tracking while powered down");
    chk_trial_mid_start:
        assert property ($fell(core_ctl.track) && core_ctl.power |-> core_ctl.trial == 12'h800)
        else $error("first trial code wrong");
    chk_busy_with_track:
        assert property ($rose(conversion_busy_pin) |-> core_ctl.track || $past(core_ctl.track))
        else $error("busy rose without acquisition");
    chk_busy_min_length:
        assert property ($fell(conversion_busy_pin) && core_ctl.power && conversion_busy_pin_oe
                         |-> busy_cnt >= 12'd21)
        else $error("conversion too short");
    chk_chan_from_write:
        assert property (psel && penable && pwrite && ce && paddr == `ACC_ADDR_POS
                         |=> core_ctl.pos_ch == $past(pwdata[4:0]))
        else $error("channel select wrong after write");
endmodule : acc_ctrl_chk

bind acc_ctrl acc_ctrl_chk acc_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig), .core_cmp(core_cmp),
    .core_ctl(core_ctl), .conversion_busy_pin(conversion_busy_pin),
    .conversion_busy_pin_oe(conversion_busy_pin_oe));
`default_nettype wire

/* sim/acc_ctrl_bench.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.svh"

module acc_ctrl_bench import acc_pkg::*;;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, q;  // bus signals and last read
    logic        e, core_cmp, busy, oe;     // last error, core and pin
    acc_trig_t   trig;                      // trigger levels
    acc_core_t   core_ctl;                  // core controls
    logic [11:0] ana, v;                    // model level and expected code
    logic [15:0] c;                         // control value
    int          n, fails, tests_run, cycles;

    acc_ctrl acc_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig(trig), .core_cmp(core_cmp),
        .core_ctl(core_ctl), .conversion_busy_pin(busy), .conversion_busy_pin_oe(oe));
    acc_core_model acc_core_model_i (.core_ctl(core_ctl), .level(ana), .core_cmp(core_cmp));

    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] x);
        tests_run++;
        if (seen !== x)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, x);
        end
    endtask : chk

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rdc

    // wait for busy, then count its high cycles
    task automatic meas(input int lim, output int cnt);
        int k;
        cnt = 0;
        k = 0;
        do begin @(negedge pclk); k++; end while (busy !== 1'b1 && k < lim);
        while (busy === 1'b1)
        begin
            cnt++;
            @(negedge pclk);
        end
        @(posedge pclk);
    endtask : meas

    // single conversion with timing and result checks
    task automatic conv(input logic [15:0] cv, input logic [11:0] lv, input int cyc,
                        input logic [31:0] res);
        int m;
        ana <= lv;
        apb(1'b1, `ACC_ADDR_CTRL, {16'h0, cv});
        meas(3000, m);
        chk(m, cyc);
        rdc(`ACC_ADDR_STAT, 32'h3);
        rdc(`ACC_ADDR_DATA, res);
        rdc(`ACC_ADDR_STAT, 32'h2);
    endtask : conv

    function automatic logic [31:0] dres(input logic [11:0] code);
        logic [11:0] t;
        t = code ^ 12'h800;
        return {{5{t[11]}}, t[11:1], 16'h0000};
    endfunction : dres

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {trig, ana} = '0;
        ce = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`ACC_ADDR_CTRL, 32'h0600);
        rdc(`ACC_ADDR_POS, 32'h0);
        rdc(`ACC_ADDR_NEG, 32'h1);
        rdc(`ACC_ADDR_STAT, 32'h0);
        rdc(32'hFFFF0520, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, `ACC_ADDR_CTRL, 32'hFFFFFFFF);
        rdc(`ACC_ADDR_STAT, 32'h0);
        chk(oe, 1'b1);
        meas(100, n);
        chk(n, 0);
        rdc(`ACC_ADDR_STAT, 32'h2);
        rdc(`ACC_ADDR_CTRL, 32'h3FFF);
        conv(16'h06E3, 12'hA5C, 54, 32'h0A5C0000);
        rdc(`ACC_ADDR_CTRL, 32'h06E0);
        for (int i = 0; i < 6; i++)
        begin
            v = 12'h123 + 12'(i);
            c = 16'h00E3 | 16'(i << 10) | 16'((i % 4) << 8);
            conv(c, v, ((2 << (i % 4)) + 19) << i, {4'h0, v, 16'h0000});
        end
        conv(16'h00EB, 12'h3FF, 21, dres(12'h3FF));
        conv(16'h00EB, 12'hC00, 21, dres(12'hC00));
        conv(16'h00F3, 12'h3FF, 21, 32'h03FF0000);
        apb(1'b1, `ACC_ADDR_POS, 32'h10);
        conv(16'h00E3, 12'h456, 1120, 32'h04560000);
        apb(1'b1, `ACC_ADDR_POS, 32'h0);
        conv(16'h00E3, 12'h457, 21, 32'h04570000);
        for (int i = 0; i < 4; i++)
        begin
            v = 12'h200 + 12'(i);
            ana <= v;
            apb(1'b1, `ACC_ADDR_CTRL, 32'h00E0 | ((i == 3) ? 32'h5 : 32'(i)));
            trig <= acc_trig_t'(4'b1000 >> i);
            meas(100, n);
            chk(n, 21);
            trig <= '0;
            repeat (30) @(posedge pclk);
            rdc(`ACC_ADDR_DATA, {4'h0, v, 16'h0000});
            rdc(`ACC_ADDR_STAT, 32'h2);
        end
        trig <= acc_trig_t'(4'b1000);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h0060);
        meas(60, n);
        chk(n, 0);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h20E0);
        meas(60, n);
        chk(n, 0);
        trig <= '0;
        @(posedge pclk);
        trig <= acc_trig_t'(4'b1000);
        meas(60, n);
        chk(n, 21);
        trig <= '0;
        rdc(`ACC_ADDR_DATA, {4'h0, v, 16'h0000});
        apb(1'b1, `ACC_ADDR_CTRL, 32'h00E4);
        repeat (30) @(posedge pclk);
        rdc(`ACC_ADDR_STAT, 32'h3);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h0064);
        rdc(`ACC_ADDR_DATA, {4'h0, v, 16'h0000});
        repeat (30) @(posedge pclk);
        rdc(`ACC_ADDR_STAT, 32'h3);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h0044);
        repeat (3) @(posedge pclk);
        rdc(`ACC_ADDR_DATA, {4'h0, v, 16'h0000});
        repeat (30) @(posedge pclk);
        apb(1'b0, `ACC_ADDR_STAT, 32'h0);
        chk(q[0], 1'b0);
        chk(busy, 1'b0);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h0020);
        repeat (50) @(posedge pclk);
        rdc(`ACC_ADDR_STAT, 32'h2);
        apb(1'b1, `ACC_ADDR_CTRL, 32'h00A3);
        meas(100, n);
        chk(n, 0);
        chk(oe, 1'b0);
        rdc(`ACC_ADDR_STAT, 32'h3);
        apb(1'b1, `ACC_ADDR_POS, 32'h5);
        apb(1'b1, `ACC_ADDR_RST, 32'h0);
        rdc(`ACC_ADDR_CTRL, 32'h0600);
        rdc(`ACC_ADDR_POS, 32'h0);
        test_done();
    end
endmodule : acc_ctrl_bench
`default_nettype wire
